// file: logic/stpc_regs.sv
// Profile control register bank with speed-mode commit and manual trigger
// What this block does
// R1 - Registers other than speed mode and the spares, which ignore writes, take written values at once, no commit.
// R2 - Writing one to update bit 0 loads pending speed mode into effect.
// R3 - Update bit also returns the profile register to its default; pending speed mode is kept.
// R4 - Update bit self-clears, so later reads return zero.
// R5 - Host should write speed mode and update bit first after power-up.
// R6 - Active profile comes from index bits 4 down to 0.
// R7 - Writing trigger bit 5 creates an internal transmit trigger event.
// R8 - Manual trigger is asynchronous to sample clock; crossed as a toggle.
// R9 - Multi-device synchronisation should use the external trigger pin instead.
// R10 - Written speed mode stays pending until the update bit is asserted.
`timescale 1ns/1ps
`default_nettype none
module stpc_regs (
    input  wire logic                ref_clk_in,
    input  wire logic                nrst_in,
    input  wire stpc_pkg::stpc_req_t req_in,
    output logic [7:0]               rdata_out,
    output logic                     rvalid_out,
    output logic [7:0]               speed_active_out,
    output logic [4:0]               profile_idx_out,
    output logic                     trig_toggle_out
);
    // Stored state
    logic [7:0] speed_pend_r;
    logic [7:0] speed_act_r;
    logic [7:0] profile_r;
    logic [7:0] rdata_r;
    logic       rvalid_r;
    logic       trig_tog_r;

    // Next values
    logic [7:0] speed_pend_nxt;
    logic [7:0] speed_act_nxt;
    logic [7:0] profile_nxt;
    logic [7:0] rdata_nxt;
    logic       rvalid_nxt;
    logic       trig_tog_nxt;

    // Decode
    logic       hit_speed;
    logic       hit_update;
    logic       hit_profile;
    logic       hit_spare;
    logic       wr_speed;
    logic       wr_profile;
    logic       wr_update;
    logic       wr_update_off;
    logic       wr_trig;
    logic [7:0] profile_view;
    logic [7:0] rd_mux;

    assign hit_speed     = (req_in.addr == stpc_pkg::ADDR_SPEED);
    assign hit_update    = (req_in.addr == stpc_pkg::ADDR_UPDATE);
    assign hit_profile   = (req_in.addr == stpc_pkg::ADDR_PROFILE);
    assign hit_spare     = (req_in.addr == stpc_pkg::ADDR_SPARE_A)
                           || (req_in.addr == stpc_pkg::ADDR_SPARE_B);
    assign wr_speed      = req_in.wr && hit_speed;
    assign wr_profile    = req_in.wr && hit_profile;
    // R2 - update bit decode
    assign wr_update     = req_in.wr && hit_update && req_in.wdata[stpc_pkg::UPD_BIT];
    // Update write with bit 0 clear is ignored altogether
    assign wr_update_off = req_in.wr && hit_update && !req_in.wdata[stpc_pkg::UPD_BIT];
    // R7 - trigger bit decode
    assign wr_trig       = wr_profile && req_in.wdata[stpc_pkg::TRIG_BIT];

    // R6 - index field view; trigger bit is not stored
    assign profile_view  = {3'h0, profile_r[stpc_pkg::IDX_MSB:0]};
    // R4 - update, spare and unmapped addresses read zero
    assign rd_mux        = hit_speed   ? speed_pend_r :
                           hit_profile ? profile_view : 8'h00;

    // R10 - pending speed capture
    assign speed_pend_nxt = wr_speed ? req_in.wdata : speed_pend_r;
    // R2 - commit speed mode
    assign speed_act_nxt  = wr_update ? speed_pend_r : speed_act_r;
    // R1 R3 - write at once, default on update
    assign profile_nxt    = wr_update  ? stpc_pkg::PROFILE_RST :
                            wr_profile ? {3'h0, req_in.wdata[stpc_pkg::IDX_MSB:0]} :
                            profile_r;
    // R8 - toggle, so the sample-clock side can resynchronise it
    assign trig_tog_nxt   = wr_trig ? ~trig_tog_r : trig_tog_r;
    assign rdata_nxt      = req_in.rd ? rd_mux : 8'h00;
    assign rvalid_nxt     = req_in.rd;

    // R10 - pending speed register
    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            speed_pend_r <= stpc_pkg::SPEED_RST;
        end else begin
            speed_pend_r <= speed_pend_nxt;
        end
    end

    // R10 - pending capture check
    a_pending_capture: assert property ( // R10
        @(posedge ref_clk_in) disable iff (!nrst_in)
        wr_speed |=> speed_pend_r == $past(req_in.wdata))
        else $error("speed write not held pending");
    // R10 - pending quiet check
    a_pending_quiet: assert property ( // R10
        @(posedge ref_clk_in) disable iff (!nrst_in)
        !wr_speed |=> $stable(speed_pend_r))
        else $error("pending speed changed without write");
    // R3 - pending kept check
    a_commit_keeps_pending: assert property ( // R3
        @(posedge ref_clk_in) disable iff (!nrst_in)
        wr_update |=> $stable(speed_pend_r))
        else $error("pending speed defaulted by update");

    // R2 - active speed register
    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            speed_act_r <= stpc_pkg::SPEED_RST;
        end else begin
            speed_act_r <= speed_act_nxt;
        end
    end

    // R2 - commit check
    a_speed_commit_load: assert property ( // R2
        @(posedge ref_clk_in) disable iff (!nrst_in)
        wr_update |=> speed_act_r == $past(speed_pend_r))
        else $error("speed mode not committed");
    // R10 - active held check
    a_speed_pending_held: assert property ( // R10
        @(posedge ref_clk_in) disable iff (!nrst_in)
        !wr_update |=> $stable(speed_act_r))
        else $error("active speed changed without update");
    // R2 - cleared bit check
    a_update_bit_clear: assert property ( // R2
        @(posedge ref_clk_in) disable iff (!nrst_in)
        wr_update_off |=> $stable(speed_act_r) && $stable(profile_r))
        else $error("update with bit 0 clear acted");

    // R1 R3 - profile register
    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            profile_r <= stpc_pkg::PROFILE_RST;
        end else begin
            profile_r <= profile_nxt;
        end
    end

    // R1 - immediate write check
    a_profile_write_now: assert property ( // R1
        @(posedge ref_clk_in) disable iff (!nrst_in)
        wr_profile |=> profile_idx_out == $past(req_in.wdata[stpc_pkg::IDX_MSB:0]))
        else $error("profile write not immediate");
    // R1 - profile hold check
    a_profile_holds: assert property ( // R1
        @(posedge ref_clk_in) disable iff (!nrst_in)
        !wr_profile && !wr_update |=> $stable(profile_r))
        else $error("profile changed without write");
    // R3 - update default check
    a_update_resets_profile: assert property ( // R3
        @(posedge ref_clk_in) disable iff (!nrst_in)
        wr_update |=> profile_r == stpc_pkg::PROFILE_RST)
        else $error("profile not defaulted on update");

    // R7 R8 - trigger toggle register
    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            trig_tog_r <= 1'h0;
        end else begin
            trig_tog_r <= trig_tog_nxt;
        end
    end

    // R7 - toggle check
    a_trig_toggles: assert property ( // R7
        @(posedge ref_clk_in) disable iff (!nrst_in)
        wr_trig |=> trig_toggle_out != $past(trig_toggle_out))
        else $error("manual trigger lost");
    // R8 - quiet check
    a_trig_quiet: assert property ( // R8
        @(posedge ref_clk_in) disable iff (!nrst_in)
        !wr_trig |=> $stable(trig_toggle_out))
        else $error("spurious trigger toggle");

    // Read answer registers
    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            rdata_r  <= 8'h00;
            rvalid_r <= 1'h0;
        end else begin
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // R4 - update readback check
    a_update_reads_zero: assert property ( // R4
        @(posedge ref_clk_in) disable iff (!nrst_in)
        req_in.rd && hit_update |=> rdata_out == 8'h00)
        else $error("update bit not self-cleared");
    // R4 - read answer check
    a_read_answer: assert property ( // R4
        @(posedge ref_clk_in) disable iff (!nrst_in)
        req_in.rd |=> rvalid_out)
        else $error("read not answered");
    // R4 - idle answer check
    a_read_idle: assert property ( // R4
        @(posedge ref_clk_in) disable iff (!nrst_in)
        !req_in.rd |=> !rvalid_out && rdata_out == 8'h00)
        else $error("read answer without read");
    // R6 - index readback check
    a_index_readback: assert property ( // R6
        @(posedge ref_clk_in) disable iff (!nrst_in)
        req_in.rd && hit_profile
        |=> rdata_out == {3'h0, $past(profile_r[stpc_pkg::IDX_MSB:0])})
        else $error("profile index readback wrong");
    // R10 - speed readback check
    a_speed_readback: assert property ( // R10
        @(posedge ref_clk_in) disable iff (!nrst_in)
        req_in.rd && hit_speed |=> rdata_out == $past(speed_pend_r))
        else $error("pending speed readback wrong");
    // R4 - spare readback check
    a_spare_reads_zero: assert property ( // R4
        @(posedge ref_clk_in) disable iff (!nrst_in)
        req_in.rd && hit_spare |=> rdata_out == stpc_pkg::SPARE_RST)
        else $error("spare register not at default");

    // Outputs straight from flip-flops
    assign rdata_out        = rdata_r;
    assign rvalid_out       = rvalid_r;
    assign speed_active_out = speed_act_r;
    assign profile_idx_out  = profile_r[stpc_pkg::IDX_MSB:0];
    assign trig_toggle_out  = trig_tog_r;
endmodule
`default_nettype wire

// file: pkg/stpc_pkg.sv
// Package: register map, field positions and reset values for the profile control bank
package stpc_pkg;
    localparam logic [12:0] ADDR_SPEED    = 13'h0002;
    localparam logic [12:0] ADDR_UPDATE   = 13'h00FF;
    localparam logic [12:0] ADDR_PROFILE  = 13'h010C;
    localparam logic [12:0] ADDR_SPARE_A  = 13'h01A0;
    localparam logic [12:0] ADDR_SPARE_B  = 13'h01A1;
    localparam int          UPD_BIT       = 0;
    localparam int          TRIG_BIT      = 5;
    localparam int          IDX_MSB       = 4;
    localparam logic [7:0]  SPEED_RST     = 8'h00;
    localparam logic [7:0]  PROFILE_RST   = 8'h00;
    localparam logic [7:0]  SPARE_RST     = 8'h00;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [12:0] addr;
        logic [7:0]  wdata;
    } stpc_req_t;
endpackage

// file: verification/stpc_host.sv
// Host model: serial-port controller issuing decoded register accesses
`timescale 1ns/1ps
`default_nettype none
module stpc_host (
    input  wire logic                ref_clk_in,
    output var stpc_pkg::stpc_req_t  req_out,
    input  wire logic [7:0]          rdata_in
);
    logic [7:0] rd_val;
    initial req_out = '0;
    // One-cycle pulse; read data is taken in the cycle after
    task automatic acc(input logic w, input logic [12:0] a, input logic [7:0] d);
        @(negedge ref_clk_in);
        req_out = {w, ~w, a, d};
        @(negedge ref_clk_in);
        req_out = '0;
        rd_val = rdata_in;
    endtask
endmodule
`default_nettype wire

// file: verification/tb_stpc_regs.sv
// Testbench for the profile control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_stpc_regs;
    logic ref_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    stpc_pkg::stpc_req_t req;
    logic [7:0] rdata, spd;
    logic rvalid, tog, tog0;
    logic [4:0] idx;
    int n_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    always #5 ref_clk_in = ~ref_clk_in;
    stpc_host u_host (.ref_clk_in(ref_clk_in), .req_out(req), .rdata_in(rdata));
    stpc_regs u_dut (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .req_in(req),
        .rdata_out(rdata), .rvalid_out(rvalid), .speed_active_out(spd),
        .profile_idx_out(idx), .trig_toggle_out(tog));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Whole run needs about 42 cycles
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 500) begin
            n_errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (6) @(negedge ref_clk_in);
        nrst_in = 1'b1;
        chk("speed reset", spd, 8'h00);
        // Speed first, then update, before other setup
        u_host.acc(1'b1, stpc_pkg::ADDR_SPEED, 8'h5A);
        chk("speed pending", spd, 8'h00);
        u_host.acc(1'b0, stpc_pkg::ADDR_SPEED, 8'h00);
        chk("pending read", u_host.rd_val, 8'h5A);
        chk("rvalid", {7'h00, rvalid}, 8'h01);
        u_host.acc(1'b1, stpc_pkg::ADDR_UPDATE, 8'h01);
        chk("speed commit", spd, 8'h5A);
        u_host.acc(1'b0, stpc_pkg::ADDR_UPDATE, 8'h00);
        chk("update clear", u_host.rd_val, 8'h00);
        $display("test commit done");
        tog0 = tog;
        u_host.acc(1'b1, stpc_pkg::ADDR_PROFILE, 8'h25);
        chk("profile idx", {3'h0, idx}, 8'h05);
        chk("trig toggle", {7'h00, tog}, {7'h00, ~tog0});
        u_host.acc(1'b0, stpc_pkg::ADDR_PROFILE, 8'h00);
        chk("profile read", u_host.rd_val, 8'h05);
        u_host.acc(1'b1, stpc_pkg::ADDR_UPDATE, 8'h01);
        chk("profile dflt", {3'h0, idx}, 8'h00);
        chk("speed kept", spd, 8'h5A);
        u_host.acc(1'b0, stpc_pkg::ADDR_SPARE_A, 8'h00);
        chk("spare read", u_host.rd_val, 8'h00);
        $display("test profile done");
        u_host.acc(1'h1, stpc_pkg::ADDR_SPEED, 8'h3C);
        chk("rvalid idle", {7'h00, rvalid}, 8'h00);
        u_host.acc(1'h1, stpc_pkg::ADDR_PROFILE, 8'h1F);
        chk("idx full", {3'h0, idx}, 8'h1F);
        chk("no trig", {7'h00, tog}, {7'h00, ~tog0});
        u_host.acc(1'h1, stpc_pkg::ADDR_UPDATE, 8'hFE);
        chk("update ignored", spd, 8'h5A);
        chk("idx kept", {3'h0, idx}, 8'h1F);
        u_host.acc(1'h1, stpc_pkg::ADDR_SPARE_B, 8'hFF);
        u_host.acc(1'h0, stpc_pkg::ADDR_SPARE_B, 8'h00);
        chk("spare b read", u_host.rd_val, 8'h00);
        @(negedge ref_clk_in);
        chk("rvalid drop", {7'h00, rvalid}, 8'h00);
        u_host.acc(1'h1, stpc_pkg::ADDR_UPDATE, 8'h01);
        chk("second commit", spd, 8'h3C);
        chk("idx dflt again", {3'h0, idx}, 8'h00);
        $display("test update done");
        u_host.acc(1'h1, stpc_pkg::ADDR_PROFILE, 8'h13);
        @(negedge ref_clk_in);
        nrst_in = 1'h0;
        repeat (2) @(negedge ref_clk_in);
        nrst_in = 1'h1;
        chk("rst speed", spd, stpc_pkg::SPEED_RST);
        chk("rst idx", {3'h0, idx}, stpc_pkg::PROFILE_RST);
        chk("rst trig", {7'h00, tog}, 8'h00);
        u_host.acc(1'h1, stpc_pkg::ADDR_PROFILE, 8'h25);
        chk("trig after rst", {7'h00, tog}, 8'h01);
        chk("idx after rst", {3'h0, idx}, 8'h05);
        $display("test reset done");
        print_verdict();
    end
endmodule
`default_nettype wire
